/* File: cfg_regs_assertions.sv */
`default_nettype none
module cfg_regs_assertions
  import cfg_regs_pkg::*;
#(
  parameter int NUM_SYNTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire ser_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [1:0] o_lock_sel,
  input wire lock_limits_s o_lock_limits,
  input wire logic [NUM_SYNTH*32-1:0] o_synth_trim,
  input wire logic o_int_filter,
  input wire logic [NUM_SYNTH*8-1:0] o_synth_phase_adv,
  input wire logic [23:0] o_div_a,
  input wire synth_cfg_s o_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // page shadow, tells the two address spaces apart
  // ---------------------------------------------------------------
  logic page_r;
  logic wr0;
  logic wr1;
  assign wr0 = i_req.wr && !page_r;
  assign wr1 = i_req.wr && page_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) page_r <= 1'b0;
    else if (i_req.wr && i_req.addr == 7'h7f) page_r <= i_req.wdata[0];
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  reset_values_a: assert property (disable iff (1'b0)
    !i_rstn |=> o_cfg.trim == 32'h046aaaab && o_lock_sel == 2'b10) else $error("bad reset");
  trim_fanout_a: assert property (
    o_synth_trim == {NUM_SYNTH{o_cfg.trim}}) else $error("trim not shared");
  phase_fanout_a: assert property (
    o_synth_phase_adv == {NUM_SYNTH{o_cfg.phase_adv}}) else $error("phase not shared");
  lock_decode_a: assert property (
    o_lock_limits.valid == (o_lock_sel != 2'b00) && (!o_lock_limits.valid ||
    o_lock_limits.wide_err == o_lock_sel[1] && o_lock_limits.long_win == &o_lock_sel))
    else $error("lock decode wrong");
  read_pulse_a: assert property (
    $past(i_rstn) |-> o_rvalid == $past(i_req.rd)) else $error("rvalid timing");
  trim_byte_a: assert property (
    wr0 && i_req.addr == 7'h73 |=> o_cfg.trim[7:0] == $past(i_req.wdata)) else $error("trim");
  filter_write_a: assert property (
    wr0 && i_req.addr == 7'h77 |=> o_int_filter == $past(i_req.wdata[0])) else $error("flt");
  page_map_a: assert property (
    wr1 && i_req.addr == 7'h00 |=> o_div_a[7:0] == $past(i_req.wdata)) else $error("page");
  page_reach_a: assert property (
    i_req.rd && i_req.addr == 7'h7f |=> o_rdata[0] == $past(page_r)) else $error("pg read");
  cover property (wr1 && i_req.addr == 7'h00);
  cover property (i_req.rd && i_req.addr == 7'h7f && page_r);
  cover property (wr0 && i_req.addr == 7'h72 && i_req.wdata[1:0] == 2'b11);
endmodule
bind dpll_synth_config_regs cfg_regs_assertions #(.NUM_SYNTH(NUM_SYNTH)) u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_lock_sel(o_lock_sel), .o_lock_limits(o_lock_limits), .o_synth_trim(o_synth_trim),
  .o_int_filter(o_int_filter), .o_synth_phase_adv(o_synth_phase_adv), .o_div_a(o_div_a),
  .o_cfg(o_cfg));
`default_nettype wire

/* File: cfg_regs_defines.svh */
`ifndef CFG_REGS_DEFINES_SVH
`define CFG_REGS_DEFINES_SVH

// ----------------------------------------------------------------------------
// byte addresses in the 8-bit internal space, plus the 7-bit serial address of the page register
// ----------------------------------------------------------------------------
`define ADDR_LOCK_CRIT 8'h72
`define ADDR_TRIM_B0 8'h73
`define ADDR_TRIM_B3 8'h76
`define ADDR_FILTER_SEL 8'h77
`define ADDR_PHASE_ADV 8'h78
`define ADDR_PAGE 8'h7f
`define ADDR_DIV_A_B0 8'h80
`define ADDR_DIV_A_B2 8'h82
`define SER_PAGE_ADDR 7'h7f

// ----------------------------------------------------------------------------
// lane counts of the multi-byte registers
// ----------------------------------------------------------------------------
`define TRIM_BYTES 4
`define DIV_A_BYTES 3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_LOCK_CRIT 8'haa
`define RST_TRIM 32'h046aaaab
`define RST_FILTER_SEL 8'h00
`define RST_PHASE_ADV 8'h00
`define RST_PAGE 8'h00
`define RST_DIV_A 24'h000002
`define RST_RDATA 8'h00
`define UNMAPPED_RDATA 8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LOCK_CRIT_MSB 1
`define PAGE_BIT 0
`define FILTER_BIT 0

`endif

/* File: cfg_regs_pkg.sv */
`default_nettype none
package cfg_regs_pkg;

  // lock criterion encoding of the 2-bit select field
  typedef enum logic [1:0] {
    LOCK_RESERVED = 2'b00,
    LOCK_1US_1S = 2'b01,
    LOCK_10US_1S = 2'b10,
    LOCK_10US_10S = 2'b11
  } lock_crit_e;

  // serial access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ser_req_s;

  // lock criterion decoded into limits
  typedef struct packed {
    logic valid;
    logic wide_err;
    logic long_win;
  } lock_limits_s;

  // configuration handed to the clock datapath
  typedef struct packed {
    lock_limits_s lock;
    logic [31:0] trim;
    logic int_filter;
    logic [7:0] phase_adv;
    logic [23:0] div_a;
  } synth_cfg_s;

endpackage
`default_nettype wire

/* File: dpll_synth_config_regs.sv */
`include "cfg_regs_defines.svh"
`default_nettype none
module dpll_synth_config_regs
  import cfg_regs_pkg::*;
#(
  parameter int NUM_SYNTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire ser_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [1:0] o_lock_sel,
  output lock_limits_s o_lock_limits,
  output logic [NUM_SYNTH*32-1:0] o_synth_trim,
  output logic o_int_filter,
  output logic [NUM_SYNTH*8-1:0] o_synth_phase_adv,
  output logic [23:0] o_div_a,
  output synth_cfg_s o_cfg
);

  // ----------------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------------
  localparam logic [31:0] TRIM_RST = `RST_TRIM;
  localparam logic [23:0] DIV_A_RST = `RST_DIV_A;
  localparam int TRIM_BYTES = `TRIM_BYTES;
  localparam int DIV_A_BYTES = `DIV_A_BYTES;
  localparam int TRIM_SPAN = int'(`ADDR_TRIM_B3) - int'(`ADDR_TRIM_B0) + 1;
  localparam int DIV_A_SPAN = int'(`ADDR_DIV_A_B2) - int'(`ADDR_DIV_A_B0) + 1;

  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  // the fan-out needs at least one synthesizer, and the lane maps must cover
  // exactly the bytes of the registers they build
  generate
    if (NUM_SYNTH < 1) begin : g_bad_num_synth
      $error("NUM_SYNTH must be at least one");
    end
    if (TRIM_BYTES * 8 != $bits(o_cfg.trim)) begin : g_bad_trim_bytes
      $error("trim byte count does not match the trim width");
    end
    if (DIV_A_BYTES * 8 != $bits(o_div_a)) begin : g_bad_div_bytes
      $error("divider byte count does not match the divider width");
    end
    if (TRIM_SPAN != TRIM_BYTES) begin : g_bad_trim_span
      $error("trim address span does not match its byte count");
    end
    if (DIV_A_SPAN != DIV_A_BYTES) begin : g_bad_div_span
      $error("divider address span does not match its byte count");
    end
    if (`LOCK_CRIT_MSB + 1 != $bits(lock_crit_e)) begin : g_bad_lock_field
      $error("lock criterion field does not match its encoding");
    end
    if (`PAGE_BIT >= $bits(i_req.wdata) || `FILTER_BIT >= $bits(i_req.wdata)) begin : g_bad_bit
      $error("page or filter bit lies outside the register byte");
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  logic [7:0] lock_crit_r;
  wire [31:0] trim_r;
  logic [7:0] filter_r;
  logic [7:0] phase_adv_r;
  logic [7:0] page_r;
  wire [23:0] div_a_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  logic [7:0] int_addr;

  page_addr_map u_map (
    .i_ser_addr(i_req.addr),
    .i_page(page_r[`PAGE_BIT]),
    .o_int_addr(int_addr)
  );

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // true when the address selects byte lane n of a register based at base
  function automatic logic lane_hit(input logic [7:0] a, input logic [7:0] base,
                                    input int n);
    lane_hit = (a == 8'(base + 8'(n)));
  endfunction

  // byte of a multi-byte register that the address selects
  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [7:0] a,
                                           input logic [7:0] base);
    pick_byte = `UNMAPPED_RDATA;
    for (int k = 0; k < TRIM_BYTES; k++) begin
      if (lane_hit(a, base, k)) begin
        pick_byte = w[k*8 +: 8];
      end
    end
  endfunction

  // single-byte registers of page 0
  wire hit_lock = (int_addr == `ADDR_LOCK_CRIT);
  wire hit_filt = (int_addr == `ADDR_FILTER_SEL);
  wire hit_phase = (int_addr == `ADDR_PHASE_ADV);
  // page register, mapped on both pages by the address extension
  wire hit_page = (int_addr == `ADDR_PAGE);
  // multi-byte registers; lanes are little-endian
  wire hit_trim = in_range(int_addr, `ADDR_TRIM_B0, `ADDR_TRIM_B3);
  wire hit_div = in_range(int_addr, `ADDR_DIV_A_B0, `ADDR_DIV_A_B2);
  // anything else reads as zero and ignores writes
  wire hit_any = hit_lock || hit_filt || hit_phase || hit_page || hit_trim || hit_div;

  // ----------------------------------------------------------------------------
  // write enables
  // ----------------------------------------------------------------------------
  wire wr_en = i_req.wr;
  wire rd_en = i_req.rd;
  wire we_lock = wr_en && hit_lock;
  wire we_filt = wr_en && hit_filt;
  wire we_phase = wr_en && hit_phase;
  wire we_page = wr_en && hit_page;
  wire [TRIM_BYTES-1:0] we_trim_lane;
  wire [DIV_A_BYTES-1:0] we_div_lane;

  // ----------------------------------------------------------------------------
  // single-byte registers; reserved bits are kept as written
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      lock_crit_r <= `RST_LOCK_CRIT;
    end else if (we_lock) begin
      lock_crit_r <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      filter_r <= `RST_FILTER_SEL;
    end else if (we_filt) begin
      filter_r <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      phase_adv_r <= `RST_PHASE_ADV;
    end else if (we_phase) begin
      phase_adv_r <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      page_r <= `RST_PAGE;
    end else if (we_page) begin
      page_r <= i_req.wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // multi-byte registers, one flip-flop byte per lane
  // ----------------------------------------------------------------------------
  // each lane is written on its own, so the host may update a single byte;
  // a partly written trim takes effect byte by byte
  genvar n;
  generate
    for (n = 0; n < TRIM_BYTES; n++) begin : g_trim_lane
      logic [7:0] lane_r;
      assign we_trim_lane[n] = wr_en && lane_hit(int_addr, `ADDR_TRIM_B0, n);
      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          lane_r <= TRIM_RST[n*8 +: 8];
        end else if (we_trim_lane[n]) begin
          lane_r <= i_req.wdata;
        end
      end
      assign trim_r[n*8 +: 8] = lane_r;
    end
    for (n = 0; n < DIV_A_BYTES; n++) begin : g_div_lane
      logic [7:0] lane_r;
      assign we_div_lane[n] = wr_en && lane_hit(int_addr, `ADDR_DIV_A_B0, n);
      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          lane_r <= DIV_A_RST[n*8 +: 8];
        end else if (we_div_lane[n]) begin
          lane_r <= i_req.wdata;
        end
      end
      assign div_a_r[n*8 +: 8] = lane_r;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  // a read shows the value before a write in the same cycle
  wire [7:0] rd_trim = pick_byte(trim_r, int_addr, `ADDR_TRIM_B0);
  wire [7:0] rd_div = pick_byte(32'(div_a_r), int_addr, `ADDR_DIV_A_B0);
  // hits are mutually exclusive, so the terms can be or-ed together
  wire [7:0] rd_mux =
    ({8{hit_lock}} & lock_crit_r) |
    ({8{hit_trim}} & rd_trim) |
    ({8{hit_filt}} & filter_r) |
    ({8{hit_phase}} & phase_adv_r) |
    ({8{hit_page}} & page_r) |
    ({8{hit_div}} & rd_div) |
    ({8{!hit_any}} & `UNMAPPED_RDATA);

  // read strobe answered one cycle after it is taken
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_en;
    end
  end

  // read data holds until the next read
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rdata_r <= `RST_RDATA;
    end else if (rd_en) begin
      rdata_r <= rd_mux;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;

  // ----------------------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------------------
  // only the low two bits choose the criterion; the reserved upper bits are
  // stored for read-back and steer nothing
  wire [1:0] lock_sel = lock_crit_r[`LOCK_CRIT_MSB:0];
  lock_limits_s limits;
  synth_cfg_s cfg_w;

  lock_crit_decode u_lock (
    .i_sel(lock_sel),
    .o_limits(limits)
  );

  assign o_lock_sel = lock_sel;
  assign o_lock_limits = limits;
  assign o_int_filter = filter_r[`FILTER_BIT];
  assign o_div_a = div_a_r;

  // the same trim and phase word fan out to every synthesizer; the trim is
  // used as fout = finit * (1 + trim/2^32) by the oscillator datapath, so a
  // positive trim raises every synthesizer frequency together
  genvar g;
  generate
    for (g = 0; g < NUM_SYNTH; g++) begin : g_synth
      wire [31:0] synth_trim = trim_r;
      wire [7:0] synth_phase = phase_adv_r;
      // the phase advance sits ahead of the post-dividers, so all of them
      // see the same shift
      assign o_synth_trim[g*32 +: 32] = synth_trim;
      assign o_synth_phase_adv[g*8 +: 8] = synth_phase;
    end
  endgenerate

  // bundle handed to the clock datapath
  always_comb begin
    cfg_w = '0;
    cfg_w.lock = limits;
    cfg_w.trim = trim_r;
    cfg_w.int_filter = filter_r[`FILTER_BIT];
    cfg_w.phase_adv = phase_adv_r;
    cfg_w.div_a = div_a_r;
  end
  assign o_cfg = cfg_w;

endmodule
`default_nettype wire

/* File: host_model.sv */
`default_nettype none
module host_model
  import cfg_regs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output ser_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_req = '0;
  // one strobe of seven address bits, then released with inverted payload
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                        output logic [8:0] q);
    @(negedge i_mclk);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_mclk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = {i_rvalid, i_rdata};
  endtask
endmodule
`default_nettype wire

/* File: lock_crit_decode.sv */
`include "cfg_regs_defines.svh"
`default_nettype none
module lock_crit_decode
  import cfg_regs_pkg::*;
(
  input wire logic [1:0] i_sel,
  output lock_limits_s o_limits
);

  // ----------------------------------------------------------------------------
  // criterion decode
  // ----------------------------------------------------------------------------
  wire lock_crit_e crit = lock_crit_e'(i_sel);
  // 00 reserved: no criterion, lock never satisfied
  assign o_limits.valid = (crit != LOCK_RESERVED);
  assign o_limits.wide_err = (crit == LOCK_10US_1S) || (crit == LOCK_10US_10S);
  assign o_limits.long_win = (crit == LOCK_10US_10S);

endmodule
`default_nettype wire

/* File: page_addr_map.sv */
`include "cfg_regs_defines.svh"
`default_nettype none
module page_addr_map
  import cfg_regs_pkg::*;
(
  input wire logic [6:0] i_ser_addr,
  input wire logic i_page,
  output logic [7:0] o_int_addr
);

  // ----------------------------------------------------------------------------
  // address extension
  // ----------------------------------------------------------------------------
  wire is_page_reg = (i_ser_addr == `SER_PAGE_ADDR);
  // page register stays visible from either page
  assign o_int_addr = is_page_reg ? `ADDR_PAGE : {i_page, i_ser_addr};

endmodule
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
`define CHK(a, e) chk(a, e)
module tb_top
  import cfg_regs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  int num_errors = 0;
  int num_checks = 0;
  ser_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] lsel;
  lock_limits_s lim;
  logic [127:0] trim;
  logic filt;
  logic [31:0] phase;
  logic [23:0] diva;
  synth_cfg_s cfg;
  logic [6:0] rst_addr [8] = '{7'h72, 7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h78, 7'h7f};
  logic [7:0] rst_val [8] = '{8'haa, 8'hab, 8'haa, 8'h6a, 8'h04, 8'h00, 8'h00, 8'h00};
  dpll_synth_config_regs DUT (.i_mclk(clk), .i_rstn(rst_n), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_lock_sel(lsel), .o_lock_limits(lim), .o_synth_trim(trim),
    .o_int_filter(filt), .o_synth_phase_adv(phase), .o_div_a(diva), .o_cfg(cfg));
  host_model u_host (.i_mclk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_req(req));
  task automatic chk(input logic [127:0] a, input logic [127:0] e);
    num_checks++;
    if (a !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [8:0] q;
    u_host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [8:0] q;
    u_host.access(1'b0, a, 8'h00, q);
    `CHK(q, {1'b1, e});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    foreach (rst_addr[i]) rd(rst_addr[i], rst_val[i]);
    for (int i = 0; i < 4; i++) begin
      wr(7'h72, 8'(i));
      `CHK({lsel, lim.valid}, {2'(i), i != 0});
    end
    // fast oscillator, about -2 percent: negative trim well inside the limit
    for (int i = 0; i < 4; i++) wr(7'(7'h73 + i), 8'hfa | 8'(i == 0));
    `CHK(trim, {4{32'hfafafafb}});
    wr(7'h77, 8'h01);
    wr(7'h78, 8'hff);
    `CHK({filt, phase}, {1'b1, {4{8'hff}}});
    wr(7'h7f, 8'h01);
    rd(7'h00, 8'h02);
    wr(7'h00, 8'h5a);
    `CHK(diva, 24'h00005a);
    rd(7'h03, 8'h00);
    rd(7'h7f, 8'h01);
    wr(7'h7f, 8'h00);
    rd(7'h72, 8'h03);
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(7'h73, 8'hab);
    rd(7'h77, 8'h00);
    `CHK(cfg, {3'b110, 32'h046aaaab, 1'b0, 8'h00, 24'h000002});
    test_done();
  end
endmodule
`default_nettype wire
